// ### hdl/rb_bank.sv
// Register bank showing each register bit access type behind a plain register port.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Read-only bits return their live value; writes change nothing.
// - A set-on-read bit becomes one when software reads it.
// - Clear-on-read bits return their value, then clear; writes do nothing.
// - Write-only bits take writes; their read value is meaningless.
// - Writing one clears a write-one-to-clear bit; zero leaves it.
// - Any write clears a write-anything-to-clear field.
// - Latch-low and latch-high bits hold until their register is read.
// - Self-clearing bits return to zero alone; writing zero does nothing.
// - Self-setting bits return to one alone; writing one does nothing.
// - Sticky status goes high on condition, follows it after being read.
// - Unread sticky status stays high even when its condition disappears.
// - Lite-reset-exempt bits keep their state through a lite reset.
// - Soft-reset-exempt bits keep their state through a software reset.
module rb_bank #(
    parameter int LATCH_W  = 4,
    parameter int STICKY_W = 4,
    parameter int EVENT_W  = 8
) (
    // Clock and hardware reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Lite and software reset requests, one cycle each
    input  wire logic                 lite_rst_req,
    input  wire logic                 soft_rst_req,
    // Register port
    input  wire rb_pkg::rb_req_t      bus_req,
    output logic [rb_pkg::DATA_W-1:0] bus_rdata,
    // Hardware conditions and events
    input  wire logic [7:0]           hw_status,
    input  wire logic [EVENT_W-1:0]   rc_event,
    input  wire logic [EVENT_W-1:0]   w1c_event,
    input  wire logic                 wac_event,
    input  wire logic [LATCH_W-1:0]   latch_high_in,
    input  wire logic [LATCH_W-1:0]   latch_low_in,
    input  wire logic [STICKY_W-1:0]  sticky_cond,
    // Control outputs
    output logic [7:0]                ctrl_plain,
    output logic [7:0]                lite_reset_exempt,
    output logic [7:0]                soft_reset_exempt,
    output logic [31:0]               wo_value,
    output logic                      sem_owned,
    output logic                      op_busy,
    output logic                      op_ready
);

    // Address decode.
    wire hit_ctrl   = bus_req.addr == rb_pkg::OFF_CTRL;
    wire hit_status = bus_req.addr == rb_pkg::OFF_STATUS;
    wire hit_sem    = bus_req.addr == rb_pkg::OFF_SEM;
    wire hit_rc     = bus_req.addr == rb_pkg::OFF_RC;
    wire hit_wo     = bus_req.addr == rb_pkg::OFF_WO;
    wire hit_w1c    = bus_req.addr == rb_pkg::OFF_W1C;
    wire hit_wac    = bus_req.addr == rb_pkg::OFF_WAC;
    wire hit_latch  = bus_req.addr == rb_pkg::OFF_LATCH;
    wire hit_sticky = bus_req.addr == rb_pkg::OFF_STICKY;
    wire hit_self   = bus_req.addr == rb_pkg::OFF_SELF;

    wire wr_ctrl    = bus_req.wr & hit_ctrl;
    wire wr_sem     = bus_req.wr & hit_sem;
    wire wr_wo      = bus_req.wr & hit_wo;
    wire wr_w1c     = bus_req.wr & hit_w1c;
    wire wr_wac     = bus_req.wr & hit_wac;
    wire wr_self    = bus_req.wr & hit_self;
    wire rd_sem     = bus_req.rd & hit_sem;
    wire rd_rc      = bus_req.rd & hit_rc;
    wire rd_latch   = bus_req.rd & hit_latch;
    wire rd_sticky  = bus_req.rd & hit_sticky;

    wire [31:0] wd  = bus_req.wdata;

    // Reset scopes. A lite or software reset clears all ordinary state;
    // each exempt field ignores only the reset that names it.
    wire clr_any    = lite_rst_req | soft_rst_req;
    wire clr_litefd = soft_rst_req;
    wire clr_softfd = lite_rst_req;

    // Control register fields.
    logic [7:0] plain_reg;
    logic [7:0] plain_next;
    logic [7:0] lite_reg;
    logic [7:0] lite_next;
    logic [7:0] softx_reg;
    logic [7:0] softx_next;

    assign plain_next = clr_any ? rb_pkg::CTRL_PLAIN_RST :
                        wr_ctrl ? wd[rb_pkg::CTRL_PLAIN_LSB +: rb_pkg::FIELD_W] : plain_reg;
    assign lite_next  = clr_litefd ? rb_pkg::CTRL_LITE_RST :
                        wr_ctrl ? wd[rb_pkg::CTRL_LITE_LSB +: rb_pkg::FIELD_W] : lite_reg;
    assign softx_next = clr_softfd ? rb_pkg::CTRL_SOFT_RST :
                        wr_ctrl ? wd[rb_pkg::CTRL_SOFT_LSB +: rb_pkg::FIELD_W] : softx_reg;

    // Hardware reset restores every field, exempt ones as well.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            plain_reg <= rb_pkg::CTRL_PLAIN_RST;
            lite_reg  <= rb_pkg::CTRL_LITE_RST;
            softx_reg <= rb_pkg::CTRL_SOFT_RST;
        end else begin
            plain_reg <= plain_next;
            lite_reg  <= lite_next;
            softx_reg <= softx_next;
        end
    end

    // Set-on-read semaphore. Writing zero releases it; writing one does nothing.
    logic sem_reg;
    logic sem_next;

    assign sem_next = clr_any ? rb_pkg::SEM_RST :
                      (rd_sem | (sem_reg & ~(wr_sem & ~wd[0])));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sem_reg <= rb_pkg::SEM_RST;
        end else begin
            sem_reg <= sem_next;
        end
    end

    // Clear-on-read flags. An event in the cycle of the read is kept.
    logic [EVENT_W-1:0] rc_reg;
    logic [EVENT_W-1:0] rc_next;

    assign rc_next = clr_any ? '0 : (rc_event | (rc_reg & ~{EVENT_W{rd_rc}}));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rc_reg <= '0;
        end else begin
            rc_reg <= rc_next;
        end
    end

    // Write-only value. It drives an output and is never read back.
    logic [31:0] wo_reg;
    logic [31:0] wo_next;

    assign wo_next = clr_any ? rb_pkg::WO_RST : (wr_wo ? wd : wo_reg);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wo_reg <= rb_pkg::WO_RST;
        end else begin
            wo_reg <= wo_next;
        end
    end

    // Write-one-to-clear flags. Set wins over a clear in the same cycle.
    logic [EVENT_W-1:0] w1c_reg;
    logic [EVENT_W-1:0] w1c_next;
    wire  [EVENT_W-1:0] w1c_mask = wr_w1c ? wd[EVENT_W-1:0] : '0;

    assign w1c_next = clr_any ? '0 : (w1c_event | (w1c_reg & ~w1c_mask));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            w1c_reg <= '0;
        end else begin
            w1c_reg <= w1c_next;
        end
    end

    // Write-anything-to-clear event counter, saturating at all ones.
    // An event in the cycle of the write is counted into the fresh value.
    logic [rb_pkg::WAC_W-1:0] wac_reg;
    logic [rb_pkg::WAC_W-1:0] wac_next;
    wire                      wac_full = &wac_reg;
    wire  [rb_pkg::WAC_W-1:0] wac_inc  = wac_reg + rb_pkg::WAC_W'(!wac_full);
    wire  [rb_pkg::WAC_W-1:0] wac_one  = rb_pkg::WAC_W'(wac_event);

    assign wac_next = clr_any ? '0 :
                      wr_wac  ? wac_one :
                      wac_event ? wac_inc : wac_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wac_reg <= '0;
        end else begin
            wac_reg <= wac_next;
        end
    end

    // Latch-high and latch-low bits, cleared by a read of their register.
    logic [LATCH_W-1:0]  lh_bits;
    logic [LATCH_W-1:0]  ll_bits;
    logic [STICKY_W-1:0] sticky_bits;

    genvar gi;
    generate
        for (gi = 0; gi < LATCH_W; gi = gi + 1) begin : g_latch
            rb_latch_bit #(
                .ACTIVE_LOW (1'b0)
            ) u_high (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .clr     (clr_any),
                .cond    (latch_high_in[gi]),
                .rd_clr  (rd_latch),
                .bit_out (lh_bits[gi])
            );
            rb_latch_bit #(
                .ACTIVE_LOW (1'b1)
            ) u_low (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .clr     (clr_any),
                .cond    (latch_low_in[gi]),
                .rd_clr  (rd_latch),
                .bit_out (ll_bits[gi])
            );
        end
        for (gi = 0; gi < STICKY_W; gi = gi + 1) begin : g_sticky
            rb_sticky_bit u_sticky (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .clr     (clr_any),
                .cond    (sticky_cond[gi]),
                .rd_clr  (rd_sticky),
                .bit_out (sticky_bits[gi])
            );
        end
    endgenerate

    // Self-clearing operation bit. Writing one starts a timed operation and
    // the bit falls by itself when it ends; a start while busy is ignored.
    rb_pkg::rb_op_state_t     op_state_reg;
    rb_pkg::rb_op_state_t     op_state_next;
    logic [rb_pkg::CNT_W-1:0] op_cnt_reg;
    logic [rb_pkg::CNT_W-1:0] op_cnt_next;
    wire                      op_start = wr_self & wd[rb_pkg::SELF_SC_BIT];
    wire  [rb_pkg::CNT_W-1:0] op_load  = rb_pkg::CNT_W'(rb_pkg::SC_CYCLES - 1);

    always_comb begin
        op_state_next = op_state_reg;
        op_cnt_next   = op_cnt_reg;
        case (op_state_reg)
            rb_pkg::OP_IDLE: begin
                if (op_start) begin
                    op_state_next = rb_pkg::OP_BUSY;
                    op_cnt_next   = op_load;
                end
            end
            rb_pkg::OP_BUSY: begin
                if (op_cnt_reg == '0) begin
                    op_state_next = rb_pkg::OP_IDLE;
                end else begin
                    op_cnt_next = op_cnt_reg - 1'b1;
                end
            end
            default: begin
                op_state_next = rb_pkg::OP_IDLE;
                op_cnt_next   = '0;
            end
        endcase
        if (clr_any) begin
            op_state_next = rb_pkg::OP_IDLE;
            op_cnt_next   = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            op_state_reg <= rb_pkg::OP_IDLE;
            op_cnt_reg   <= '0;
        end else begin
            op_state_reg <= op_state_next;
            op_cnt_reg   <= op_cnt_next;
        end
    end

    // Self-setting ready bit. Writing zero drops it for a fixed time, after
    // which it rises again by itself; writing one does nothing.
    logic                     rdy_reg;
    logic                     rdy_next;
    logic [rb_pkg::CNT_W-1:0] rdy_cnt_reg;
    logic [rb_pkg::CNT_W-1:0] rdy_cnt_next;
    wire                      rdy_drop = wr_self & ~wd[rb_pkg::SELF_SS_BIT];
    wire  [rb_pkg::CNT_W-1:0] rdy_load = rb_pkg::CNT_W'(rb_pkg::SS_CYCLES - 1);
    wire                      rdy_done = ~rdy_reg & (rdy_cnt_reg == '0);

    assign rdy_next     = clr_any ? rb_pkg::READY_RST :
                          rdy_drop ? 1'b0 : (rdy_reg | rdy_done);
    assign rdy_cnt_next = (clr_any | rdy_done) ? '0 :
                          rdy_drop ? rdy_load :
                          (~rdy_reg ? rdy_cnt_reg - 1'b1 : rdy_cnt_reg);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdy_reg     <= rb_pkg::READY_RST;
            rdy_cnt_reg <= '0;
        end else begin
            rdy_reg     <= rdy_next;
            rdy_cnt_reg <= rdy_cnt_next;
        end
    end

    // Read values. Reserved bits and unmapped offsets read as zero, and the
    // write-only register reads as zero so nothing leaks from it.
    wire busy_bit = op_state_reg == rb_pkg::OP_BUSY;

    wire [31:0] rv_ctrl   = {8'h00, softx_reg, lite_reg, plain_reg};
    wire [31:0] rv_status = {22'h00_0000, busy_bit, sem_reg, hw_status};
    wire [31:0] rv_sem    = {31'h0000_0000, sem_reg};
    wire [31:0] rv_rc     = 32'(rc_reg);
    wire [31:0] rv_w1c    = 32'(w1c_reg);
    wire [31:0] rv_wac    = 32'(wac_reg);
    wire [31:0] rv_latch  = 32'(lh_bits) | (32'(ll_bits) << rb_pkg::LATCH_LOW_LSB);
    wire [31:0] rv_sticky = 32'(sticky_bits);
    wire [31:0] rv_self   = {30'h0000_0000, rdy_reg, busy_bit};

    wire [31:0] rd_mux = hit_ctrl   ? rv_ctrl   :
                         hit_status ? rv_status :
                         hit_sem    ? rv_sem    :
                         hit_rc     ? rv_rc     :
                         hit_w1c    ? rv_w1c    :
                         hit_wac    ? rv_wac    :
                         hit_latch  ? rv_latch  :
                         hit_sticky ? rv_sticky :
                         hit_self   ? rv_self   : 32'h0000_0000;

    // Read data stand only in the cycle after the read strobe.
    logic [31:0] rdata_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= bus_req.rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign bus_rdata         = rdata_reg;
    assign ctrl_plain        = plain_reg;
    assign lite_reset_exempt = lite_reg;
    assign soft_reset_exempt = softx_reg;
    assign wo_value          = wo_reg;
    assign sem_owned         = sem_reg;
    assign op_busy           = busy_bit;
    assign op_ready          = rdy_reg;

endmodule

// ### hdl/rb_latch_bit.sv
// One latch-high or latch-low bit that is cleared by a read of its register.
`timescale 1ns/1ps
module rb_latch_bit #(
    parameter bit ACTIVE_LOW = 1'b0
) (
    // Clock and resets
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic clr,
    // Condition and read
    input  wire logic cond,
    input  wire logic rd_clr,
    // Reported value
    output logic      bit_out
);

    logic seen_reg;
    logic seen_next;
    wire  cond_hit = ACTIVE_LOW ? ~cond : cond;

    // A condition in the cycle of the read survives it.
    assign seen_next = cond_hit | (seen_reg & ~rd_clr);
    assign bit_out   = ACTIVE_LOW ? ~seen_reg : seen_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n || clr) begin
            seen_reg <= 1'b0;
        end else begin
            seen_reg <= seen_next;
        end
    end

endmodule

// ### hdl/rb_sticky_bit.sv
// One sticky latch-high status bit that follows its condition once read.
`timescale 1ns/1ps
module rb_sticky_bit (
    // Clock and resets
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic clr,
    // Condition and read
    input  wire logic cond,
    input  wire logic rd_clr,
    // Reported value
    output logic      bit_out
);

    logic bit_reg;
    logic read_reg;
    logic bit_next;
    logic read_next;

    // Unread, the bit holds; once read, it drops with the condition.
    assign bit_next  = cond | (bit_reg & ~read_reg);
    // A read only counts while the bit is high; a new rise is unread again.
    assign read_next = bit_reg & (read_reg | rd_clr);
    assign bit_out   = bit_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n || clr) begin
            bit_reg  <= 1'b0;
            read_reg <= 1'b0;
        end else begin
            bit_reg  <= bit_next;
            read_reg <= read_next;
        end
    end

endmodule

// ### pkg/rb_pkg.sv
// Constants, types and register map of the register bit access bank.
package rb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets in bytes.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_SEM    = 8'h08;
    localparam logic [7:0] OFF_RC     = 8'h0c;
    localparam logic [7:0] OFF_WO     = 8'h10;
    localparam logic [7:0] OFF_W1C    = 8'h14;
    localparam logic [7:0] OFF_WAC    = 8'h18;
    localparam logic [7:0] OFF_LATCH  = 8'h1c;
    localparam logic [7:0] OFF_STICKY = 8'h20;
    localparam logic [7:0] OFF_SELF   = 8'h24;

    // Field positions.
    localparam int CTRL_PLAIN_LSB = 0;
    localparam int CTRL_LITE_LSB  = 8;
    localparam int CTRL_SOFT_LSB  = 16;
    localparam int FIELD_W        = 8;
    localparam int STATUS_SEM_BIT = 8;
    localparam int STATUS_BSY_BIT = 9;
    localparam int LATCH_LOW_LSB  = 8;
    localparam int SELF_SC_BIT    = 0;
    localparam int SELF_SS_BIT    = 1;
    localparam int WAC_W          = 16;

    // Values after reset.
    localparam logic [7:0]  CTRL_PLAIN_RST = 8'h00;
    localparam logic [7:0]  CTRL_LITE_RST  = 8'h01;
    localparam logic [7:0]  CTRL_SOFT_RST  = 8'h02;
    localparam logic [31:0] WO_RST         = 32'h0000_0000;
    localparam logic        SEM_RST        = 1'b0;
    localparam logic        READY_RST      = 1'b1;

    // Self-clearing and self-setting times, rounded up to whole cycles.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SC_TIME_NS    = 100;
    localparam int SS_TIME_NS    = 200;
    localparam int SC_CYCLES     = (SC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SS_CYCLES     = (SS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 4;

    typedef enum logic [0:0] {
        OP_IDLE,
        OP_BUSY
    } rb_op_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } rb_req_t;

endpackage

// ### tb/rb_bank_chk.sv
// Concurrent checks on the ports of the register bit access bank.
`timescale 1ns/1ps
module rb_bank_chk (
    // Clock and resets
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire logic                      lite_rst_req,
    input wire logic                      soft_rst_req,
    // Register port
    input wire rb_pkg::rb_req_t           bus_req,
    input wire logic [rb_pkg::DATA_W-1:0] bus_rdata,
    input wire logic [7:0]                hw_status,
    // Control outputs
    input wire logic [7:0]                ctrl_plain,
    input wire logic [7:0]                lite_reset_exempt,
    input wire logic [7:0]                soft_reset_exempt,
    input wire logic [31:0]               wo_value,
    input wire logic                      sem_owned,
    input wire logic                      op_busy,
    input wire logic                      op_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Reset requests clear state but not read data, so checks of bus effects exclude them.
    wire quiet    = !lite_rst_req && !soft_rst_req;
    wire rd_stat  = bus_req.rd && bus_req.addr == rb_pkg::OFF_STATUS;
    wire rd_sem   = bus_req.rd && bus_req.addr == rb_pkg::OFF_SEM;
    wire wr_wo    = bus_req.wr && bus_req.addr == rb_pkg::OFF_WO;

    status_live_a: assert property (rd_stat && quiet |=> bus_rdata[7:0] == $past(hw_status)
        && bus_rdata[9:8] == {$past(op_busy), $past(sem_owned)}) else $error("status read mismatch");
    sem_read_a: assert property (rd_sem && quiet |=> sem_owned && bus_rdata[0] == $past(sem_owned))
        else $error("semaphore read did not set");
    wo_write_a: assert property (wr_wo && quiet |=> wo_value == $past(bus_req.wdata))
        else $error("write-only value not taken");
    wo_read_a: assert property ($past(bus_req.rd && bus_req.addr == rb_pkg::OFF_WO) |-> bus_rdata == '0)
        else $error("write-only read not zero");
    busy_time_a: assert property ($rose(op_busy) |-> op_busy [*4] ##1 !op_busy)
        else $error("busy bit length wrong");
    ready_back_a: assert property ($fell(op_ready) |-> !op_ready [*7] ##[1:3] op_ready)
        else $error("ready bit did not return");
    lite_keep_a: assert property (lite_rst_req && !soft_rst_req |=>
        lite_reset_exempt == $past(lite_reset_exempt) && ctrl_plain == rb_pkg::CTRL_PLAIN_RST
        && soft_reset_exempt == rb_pkg::CTRL_SOFT_RST) else $error("lite reset handling wrong");
    soft_keep_a: assert property (soft_rst_req && !lite_rst_req |=>
        soft_reset_exempt == $past(soft_reset_exempt) && ctrl_plain == rb_pkg::CTRL_PLAIN_RST
        && lite_reset_exempt == rb_pkg::CTRL_LITE_RST) else $error("soft reset handling wrong");
    hw_reset_a: assert property (disable iff (1'b0) !rst_n |=> ctrl_plain == rb_pkg::CTRL_PLAIN_RST
        && lite_reset_exempt == rb_pkg::CTRL_LITE_RST && soft_reset_exempt == rb_pkg::CTRL_SOFT_RST
        && wo_value == '0 && !sem_owned && !op_busy && op_ready && bus_rdata == '0)
        else $error("hardware reset defaults wrong");
endmodule

bind rb_bank rb_bank_chk rb_bank_chk_inst (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .lite_rst_req      (lite_rst_req),
    .soft_rst_req      (soft_rst_req),
    .bus_req           (bus_req),
    .bus_rdata         (bus_rdata),
    .hw_status         (hw_status),
    .ctrl_plain        (ctrl_plain),
    .lite_reset_exempt (lite_reset_exempt),
    .soft_reset_exempt (soft_reset_exempt),
    .wo_value          (wo_value),
    .sem_owned         (sem_owned),
    .op_busy           (op_busy),
    .op_ready          (op_ready)
);

// ### tb/rb_bank_tb.sv
// Self-checking testbench of the register bit access bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t: got %h, expected %h", $time, (got), (exp)); end end
module rb_bank_tb;
    logic            mclk;
    logic            rst_n;
    logic            lite_rst_req;
    logic            soft_rst_req;
    rb_pkg::rb_req_t req;
    logic [31:0]     bus_rdata;
    logic [7:0]      hw_status;
    logic [7:0]      rc_event;
    logic [7:0]      w1c_event;
    logic            wac_event;
    logic [3:0]      latch_high_in;
    logic [3:0]      latch_low_in;
    logic [3:0]      sticky_cond;
    logic [7:0]      ctrl_plain;
    logic [7:0]      lite_reset_exempt;
    logic [7:0]      soft_reset_exempt;
    logic [31:0]     wo_value;
    logic            sem_owned;
    logic            op_busy;
    logic            op_ready;
    logic [31:0]     d;
    logic [31:0]     x;
    int              bad_count;
    int              checks;

    rb_bank rb_bank_inst (
        .mclk(mclk), .rst_n(rst_n), .lite_rst_req(lite_rst_req), .soft_rst_req(soft_rst_req),
        .bus_req(req), .bus_rdata(bus_rdata), .hw_status(hw_status), .rc_event(rc_event),
        .w1c_event(w1c_event), .wac_event(wac_event), .latch_high_in(latch_high_in),
        .latch_low_in(latch_low_in), .sticky_cond(sticky_cond), .ctrl_plain(ctrl_plain),
        .lite_reset_exempt(lite_reset_exempt), .soft_reset_exempt(soft_reset_exempt),
        .wo_value(wo_value), .sem_owned(sem_owned), .op_busy(op_busy), .op_ready(op_ready)
    );

    function automatic logic [31:0] ctrl_word(input logic [7:0] p, input logic [7:0] l, input logic [7:0] s);
        return {8'h00, s, l, p};
    endfunction
    function automatic logic [7:0] w1c_left(input logic [7:0] set_v, input logic [7:0] clr_v);
        return set_v & ~clr_v;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        req.addr  <= a;
        req.wdata <= v;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr    <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd   <= 1'b0;
        #1;
        v = bus_rdata;
    endtask
    task automatic done_test(input string n);
        $display("Test %s done, %0d checks so far", n, checks);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #(25 * 4000);
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        lite_rst_req = 1'b0;
        soft_rst_req = 1'b0;
        req = '0;
        hw_status = 8'h00;
        rc_event = 8'h00;
        w1c_event = 8'h00;
        wac_event = 1'b0;
        latch_high_in = 4'h0;
        latch_low_in = 4'hf;
        sticky_cond = 4'h0;
        void'($urandom(32'h313f));
        step(6);
        rst_n <= 1'b1;
        rd(rb_pkg::OFF_CTRL, d);
        `CHK(d, ctrl_word(rb_pkg::CTRL_PLAIN_RST, rb_pkg::CTRL_LITE_RST, rb_pkg::CTRL_SOFT_RST))
        rd(rb_pkg::OFF_LATCH, d);
        `CHK(d & 32'h0000_0f0f, 32'h0000_0f00)
        rd(rb_pkg::OFF_SEM, d);
        `CHK(d[0], 1'b0)
        rd(rb_pkg::OFF_SEM, d);
        `CHK(d[0], 1'b1)
        done_test("defaults");
        for (int i = 0; i < 4; i++) begin
            x = $urandom();
            x[15:8] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : x[15:8];
            @(posedge mclk);
            hw_status <= x[7:0];
            w1c_event <= 8'hff;
            @(posedge mclk);
            w1c_event <= 8'h00;
            wr(rb_pkg::OFF_STATUS, ~x & 32'h0000_03ff);
            rd(rb_pkg::OFF_STATUS, d);
            `CHK(d[7:0], x[7:0])
            wr(rb_pkg::OFF_W1C, {24'h0000_00, x[15:8]});
            rd(rb_pkg::OFF_W1C, d);
            `CHK(d, {24'h0000_00, w1c_left(8'hff, x[15:8])})
            wr(rb_pkg::OFF_WO, x);
            `CHK(wo_value, x)
            rd(rb_pkg::OFF_WO, d);
            `CHK(d, 32'h0000_0000)
        end
        done_test("random access");
        x = ($urandom() & 32'h0000_007e) | 32'h0000_0001;
        @(posedge mclk);
        rc_event <= x[7:0];
        @(posedge mclk);
        rc_event <= 8'h00;
        wr(rb_pkg::OFF_RC, 32'h0000_00ff);
        rd(rb_pkg::OFF_RC, d);
        `CHK(d, x)
        rd(rb_pkg::OFF_RC, d);
        `CHK(d, 32'h0000_0000)
        for (int j = 0; j < 2; j++) begin
            @(posedge mclk);
            wac_event <= 1'b1;
            step(5);
            wac_event <= 1'b0;
            rd(rb_pkg::OFF_WAC, d);
            `CHK(d, 32'h0000_0005)
            wr(rb_pkg::OFF_WAC, (j == 0) ? 32'h0000_0000 : ($urandom() & 32'h0000_ffff));
            rd(rb_pkg::OFF_WAC, d);
            `CHK(d, 32'h0000_0000)
        end
        done_test("clearing");
        @(posedge mclk);
        latch_high_in <= 4'h5;
        latch_low_in <= 4'hd;
        sticky_cond <= 4'hf;
        @(posedge mclk);
        latch_high_in <= 4'h0;
        latch_low_in <= 4'hf;
        sticky_cond <= 4'h0;
        step(3);
        rd(rb_pkg::OFF_LATCH, d);
        `CHK(d & 32'h0000_0f0f, 32'h0000_0d05)
        rd(rb_pkg::OFF_LATCH, d);
        `CHK(d & 32'h0000_0f0f, 32'h0000_0f00)
        rd(rb_pkg::OFF_STICKY, d);
        `CHK(d, 32'h0000_000f)
        rd(rb_pkg::OFF_STICKY, d);
        `CHK(d, 32'h0000_0000)
        @(posedge mclk);
        sticky_cond <= 4'h1;
        rd(rb_pkg::OFF_STICKY, d);
        `CHK(d, 32'h0000_0001)
        rd(rb_pkg::OFF_STICKY, d);
        `CHK(d, 32'h0000_0001)
        @(posedge mclk);
        sticky_cond <= 4'h0;
        step(2);
        rd(rb_pkg::OFF_STICKY, d);
        `CHK(d, 32'h0000_0000)
        done_test("latches");
        wr(rb_pkg::OFF_SELF, 32'h0000_0003);
        `CHK(op_busy, 1'b1)
        wr(rb_pkg::OFF_SELF, 32'h0000_0002);
        `CHK(op_busy, 1'b1)
        step(6);
        `CHK(op_busy, 1'b0)
        wr(rb_pkg::OFF_SELF, 32'h0000_0002);
        `CHK({op_busy, op_ready}, 2'b01)
        wr(rb_pkg::OFF_SELF, 32'h0000_0000);
        `CHK(op_ready, 1'b0)
        step(10);
        rd(rb_pkg::OFF_SELF, d);
        `CHK(d[1:0], 2'b10)
        done_test("self timed");
        x = $urandom() & 32'h00ff_ffff;
        wr(rb_pkg::OFF_CTRL, x);
        @(posedge mclk);
        lite_rst_req <= 1'b1;
        @(posedge mclk);
        lite_rst_req <= 1'b0;
        #1;
        `CHK({soft_reset_exempt, lite_reset_exempt, ctrl_plain}, {rb_pkg::CTRL_SOFT_RST, x[15:8], 8'h00})
        wr(rb_pkg::OFF_CTRL, x);
        @(posedge mclk);
        soft_rst_req <= 1'b1;
        @(posedge mclk);
        soft_rst_req <= 1'b0;
        #1;
        `CHK({soft_reset_exempt, lite_reset_exempt, ctrl_plain}, {x[23:16], rb_pkg::CTRL_LITE_RST, 8'h00})
        wr(8'h40, x);
        rd(8'h40, d);
        `CHK(d, 32'h0000_0000)
        wr(rb_pkg::OFF_CTRL, x);
        wr(rb_pkg::OFF_WO, x);
        @(posedge mclk);
        rst_n <= 1'b0;
        step(2);
        rst_n <= 1'b1;
        #1;
        `CHK({soft_reset_exempt, lite_reset_exempt, ctrl_plain}, 24'h02_0100)
        `CHK(wo_value, 32'h0000_0000)
        done_test("resets");
        report_and_stop();
    end
endmodule
